// [hw/rng_byte_source.sv]
// random byte source: oscillators, byte assembly, register port, interrupt
//
// Behaviour
// - enable bit 30 starts entropy collection; clear keeps the unit idle
// - when valid, bits 7:0 of the control register show the byte
// - byte field keeps the latest valid byte, replaced only by newer one
// - a read of the control register clears the valid flag, except in the cycle where a new byte completes
// - valid flag at bit 31, read-only, one only while byte is valid
// - randomness comes from ring oscillator jitter, not a pseudo generator
// - oscillators are generic latches, no vendor primitives or attributes
`timescale 1ns/1ps
module rng_byte_source #(
  parameter int NUM_OSC    = rng_pkg::NUM_OSC,
  parameter int OSC_STAGES = rng_pkg::OSC_STAGES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  // interrupt
  output logic             irq
);

  initial begin
    if (NUM_OSC < 1 || NUM_OSC > 16)
      $error("rng_byte_source: NUM_OSC must be 1..16");
  end

  rng_pkg::bus_req_s req;
  assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};

  // state
  logic                 enable_reg;
  logic                 valid_reg;
  logic           [7:0] byte_reg;
  logic           [7:0] shift_reg;
  logic           [2:0] count_reg;
  logic                 irq_stat_reg;
  logic                 irq_mask_reg;
  logic          [31:0] rdata_reg;
  logic [NUM_OSC-1:0]   osc_bits;

  // address decode
  wire logic sel_ctrl = (req.addr == rng_pkg::CTRL_ADDR);
  wire logic sel_stat = (req.addr == rng_pkg::IRQ_STAT_ADDR);
  wire logic sel_mask = (req.addr == rng_pkg::IRQ_MASK_ADDR);
  wire logic ctrl_rd  = req.rd && sel_ctrl;

  // oscillator bank, each cell an independent ring
  generate
    for (genvar k = 0; k < NUM_OSC; k++) begin : g_osc
      ring_osc_cell #(
        .STAGES (OSC_STAGES + 2*k)
      ) u_cell (
        .clock   (clock),
        .sys_rst (sys_rst),
        .run     (enable_reg),
        .bit_out (osc_bits[k])
      );
    end
  endgenerate

  // combine oscillators into one raw bit
  wire logic raw_bit  = ^osc_bits;
  wire logic last_bit  = (count_reg == 3'(rng_pkg::BYTE_BITS-1));
  wire logic byte_done = enable_reg && last_bit;
  wire logic stat_clr  = req.wr && sel_stat
                         && req.wdata[rng_pkg::IRQ_BYTE_BIT];
  wire logic [7:0] new_byte = {shift_reg[6:0], raw_bit};

  // enable register, writable field only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      enable_reg <= rng_pkg::ENABLE_RST;
    end else if (req.wr && sel_ctrl) begin
      enable_reg <= req.wdata[rng_pkg::ENABLE_BIT];
    end
  end

  // bit collection into bytes
  always_ff @(posedge clock) begin
    if (sys_rst || !enable_reg) begin
      shift_reg <= rng_pkg::BYTE_RST;
      count_reg <= 3'd0;
    end else begin
      shift_reg <= new_byte;
      count_reg <= count_reg + 3'd1;
    end
  end

  // latest byte held until a newer one arrives
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      byte_reg <= rng_pkg::BYTE_RST;
    end else if (byte_done) begin
      byte_reg <= new_byte;
    end
  end

  // valid flag: new byte sets, read clears; set wins over clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      valid_reg <= 1'b0;
    end else if (byte_done) begin
      valid_reg <= 1'b1;
    end else if (ctrl_rd || !enable_reg) begin
      valid_reg <= 1'b0;
    end
  end

  // interrupt status (write one to clear) and mask
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_stat_reg <= rng_pkg::IRQ_RST;
      irq_mask_reg <= rng_pkg::IRQ_RST;
    end else begin
      if (byte_done) begin
        irq_stat_reg <= 1'b1;
      end else if (stat_clr) begin
        irq_stat_reg <= 1'b0;
      end
      if (req.wr && sel_mask) begin
        irq_mask_reg <= req.wdata[rng_pkg::IRQ_BYTE_BIT];
      end
    end
  end

  assign irq = irq_stat_reg && irq_mask_reg;

  // read mux; unused and unmapped read as zero
  wire logic [31:0] ctrl_word = {valid_reg, enable_reg, 22'h00_0000,
                                 byte_reg};
  wire logic [31:0] rd_mux = sel_ctrl ? ctrl_word :
                             sel_stat ? {31'h0000_0000, irq_stat_reg} :
                             sel_mask ? {31'h0000_0000, irq_mask_reg} :
                             32'h0000_0000;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req.rd) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign rdata = rdata_reg;

  // checks
  a_read_clears_valid: assert property (@(posedge clock) disable iff (sys_rst)
    ctrl_rd && !byte_done |=> !valid_reg)
    else $error("valid not cleared by read");
  a_byte_sets_valid: assert property (@(posedge clock) disable iff (sys_rst)
    byte_done |=> valid_reg && byte_reg == $past(new_byte))
    else $error("byte not captured");
  a_byte_held: assert property (@(posedge clock) disable iff (sys_rst)
    !byte_done |=> $stable(byte_reg))
    else $error("byte changed without new sample");
  a_idle_no_valid: assert property (@(posedge clock) disable iff (sys_rst)
    !enable_reg ##1 !enable_reg |-> !valid_reg && count_reg == 3'd0)
    else $error("activity while disabled");
  a_enable_write: assert property (@(posedge clock) disable iff (sys_rst)
    req.wr && sel_ctrl |=> enable_reg == $past(wdata[30]))
    else $error("enable not written");
  a_read_data: assert property (@(posedge clock) disable iff (sys_rst)
    ctrl_rd |=> rdata[31] == $past(valid_reg) && rdata[7:0] == $past(byte_reg)
    && rdata[29:8] == 22'h00_0000)
    else $error("bad control read");
  a_valid_ro: assert property (@(posedge clock) disable iff (sys_rst)
    req.wr && sel_ctrl && !byte_done && !valid_reg |=> !valid_reg)
    else $error("valid set by write");
  a_byte_period: assert property (@(posedge clock) disable iff (sys_rst)
    byte_done ##1 enable_reg[*8] |-> byte_done)
    else $error("byte cadence wrong");
  c_byte_ready: cover property (@(posedge clock) byte_done);
  c_read_valid: cover property (@(posedge clock) ctrl_rd && valid_reg);
  c_irq: cover property (@(posedge clock) irq);

endmodule : rng_byte_source

// [hw/rng_pkg.sv]
// package: register layout and constants of the ring-oscillator random source
package rng_pkg;

  // register map (byte address of the single control/status word)
  localparam logic [31:0] CTRL_ADDR    = 32'hffff_ffb8;

  // field positions
  localparam int          VALID_BIT    = 31;
  localparam int          ENABLE_BIT   = 30;
  localparam int          INT_ST_ADDR_OFS = 0;
  localparam int          DATA_MSB     = 7;
  localparam int          DATA_LSB     = 0;

  // extra registers for the interrupt logic
  localparam logic [31:0] IRQ_STAT_ADDR = 32'hffff_ffbc;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'hffff_ffc0;
  localparam int          IRQ_BYTE_BIT  = 0;

  // reset values
  localparam logic        ENABLE_RST   = 1'b0;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic        IRQ_RST      = 1'b0;

  // sizing of the entropy core
  localparam int          NUM_OSC      = 3;
  localparam int          OSC_STAGES   = 5;

  // sampling: bits collected per byte
  localparam int          BYTE_BITS    = 8;

  // register bus request carried as one bundle
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

endpackage : rng_pkg

// [hw/ring_osc_cell.sv]
// one latch-based ring oscillator with a synchronised output bit
`timescale 1ns/1ps
module ring_osc_cell #(
  parameter int STAGES = 5
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // control
  input  wire logic run,
  // output
  output logic      bit_out
);

  initial begin
    if (STAGES < 3 || STAGES % 2 == 0)
      $error("ring_osc_cell: STAGES must be odd and at least 3");
  end

  logic [STAGES-1:0] ring;
  logic              smp_a_reg;
  logic              smp_b_reg;

  // inverting transparent latches chained into a loop; jitter is entropy.
  // the first and last stages open on opposite clock levels, so the loop
  // is never transparent all round: no zero-delay race in simulation
  generate
    for (genvar i = 0; i < STAGES; i++) begin : g_stage
      wire logic fb = (i == 0) ? ring[STAGES-1] : ring[i-1];
      if (i == 0) begin : g_first
        always_latch begin
          if (!run) begin
            ring[i] = 1'b0;
          end else if (clock) begin
            ring[i] = ~fb;
          end
        end
      end else if (i == STAGES-1) begin : g_last
        always_latch begin
          if (!run) begin
            ring[i] = 1'b0;
          end else if (!clock) begin
            ring[i] = ~fb;
          end
        end
      end else begin : g_mid
        always_latch begin
          if (!run) begin
            ring[i] = 1'b0;
          end else begin
            ring[i] = ~fb;
          end
        end
      end
    end
  endgenerate

  // two-flop synchroniser into the clock domain
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      smp_a_reg <= 1'b0;
      smp_b_reg <= 1'b0;
    end else begin
      smp_a_reg <= ring[STAGES-1];
      smp_b_reg <= smp_a_reg;
    end
  end

  assign bit_out = smp_b_reg;

endmodule : ring_osc_cell

// [tb/test_rng_byte_source.sv]
// self-checking bench for the ring-oscillator random byte source
`timescale 1ns/1ps
module test_rng_byte_source;
  logic        clock    = 1'b0;
  logic        sys_rst  = 1'b1;
  logic [31:0] addr     = 32'h0000_0000;
  logic [31:0] wdata    = 32'h0000_0000;
  logic        wr_stb   = 1'b0;
  logic        rd_stb   = 1'b0;
  logic [31:0] rdata;
  logic        irq;
  logic [31:0] seed     = 32'h25a7_6778;
  logic [31:0] got;
  logic [7:0]  held;
  int          fails    = 0;
  int          compares = 0;
  int          model_en = 0;  // model of the enable bit

  // design under test
  rng_byte_source uut (
    .clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq));

  // 20 MHz clock
  always #25 clock = ~clock;

  // next value of the stimulus shift register
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // compare and count
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data taken in the cycle after
  task automatic rd(input logic [31:0] a);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 got = rdata;
  endtask : rd

  // control write with random junk in every bit but enable
  task automatic set_en(input int en);
    seed     = lfsr(seed);
    model_en = en;
    wr(rng_pkg::CTRL_ADDR, {seed[31], en[0], seed[29:0]});
  endtask : set_en

  // control read against the model, byte content left out
  task automatic chk_ctrl(input string what, input int v);
    rd(rng_pkg::CTRL_ADDR);
    chk(what, {v[0], model_en[0], 30'h0}, got & 32'hffff_ff00);
  endtask : chk_ctrl

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // watchdog: the tests need under 200 cycles
  initial begin
    repeat (2000) @(posedge clock);
    fails++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    chk_ctrl("ctrl after reset", 0);
    chk("irq after reset", 32'h0, {31'h0, irq});
    seed = lfsr(seed);
    rd({20'h0_0000, seed[11:0]});
    chk("unmapped read", 32'h0000_0000, got);
    $display("test reset done");
    // a byte arrives once enabled, a read clears the flag
    wr(rng_pkg::IRQ_MASK_ADDR, 32'h0000_0000);
    set_en(1);
    repeat (10) @(posedge clock);
    chk_ctrl("valid after enable", 1);
    chk("irq while masked", 32'h0, {31'h0, irq});
    chk_ctrl("valid after read", 0);
    rd(rng_pkg::IRQ_STAT_ADDR);
    chk("byte event", 32'h1, got & 32'h0000_0001);
    $display("test enable done");
    // unmasking raises the line, clearing drops it
    wr(rng_pkg::IRQ_MASK_ADDR, 32'h0000_0001);
    #1 chk("irq unmasked", 32'h1, {31'h0, irq});
    set_en(0);
    chk_ctrl("ctrl after disable", 0);
    wr(rng_pkg::IRQ_STAT_ADDR, 32'h0000_0001);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    // idle unit makes no bytes and keeps the last one
    held = got[7:0];
    repeat (20) @(posedge clock);
    rd(rng_pkg::IRQ_STAT_ADDR);
    chk("no event while idle", 32'h0, got);
    chk_ctrl("idle ctrl", 0);
    chk("byte held", {24'h00_0000, held}, {24'h00_0000, got[7:0]});
    $display("test idle done");
    // software reset: disabled a while, then enabled again
    set_en(1);
    repeat (10) @(posedge clock);
    chk_ctrl("valid after re-enable", 1);
    $display("test re-enable done");
    print_verdict();
  end
endmodule : test_rng_byte_source
